// *** design/pin_xbar_pkg.sv ***
// constants and types shared by the priority port crossbar
package pin_xbar_pkg;

  // pin and signal counts; flat pin index is port*8+bit, port 3 has five bits
  localparam int NUM_PINS     = 29;
  localparam int NUM_ROUTABLE = 20;
  localparam int NUM_SIGS     = 21;
  localparam int NUM_PORTS    = 4;
  localparam int NUM_SKIP     = 3;

  // peripheral signal indices in descending priority
  localparam logic [4:0] SIG_TX     = 5'h00;
  localparam logic [4:0] SIG_RX     = 5'h01;
  localparam logic [4:0] SIG_SCK    = 5'h02;
  localparam logic [4:0] SIG_MISO   = 5'h03;
  localparam logic [4:0] SIG_MOSI   = 5'h04;
  localparam logic [4:0] SIG_NSS    = 5'h05;
  localparam logic [4:0] SIG_SDA    = 5'h06;
  localparam logic [4:0] SIG_SCL    = 5'h07;
  localparam logic [4:0] SIG_CP0    = 5'h08;
  localparam logic [4:0] SIG_CP0A   = 5'h09;
  localparam logic [4:0] SIG_CP1    = 5'h0A;
  localparam logic [4:0] SIG_CP1A   = 5'h0B;
  localparam logic [4:0] SIG_SYSCLK = 5'h0C;
  localparam logic [4:0] SIG_CEX0   = 5'h0D;
  localparam logic [4:0] SIG_ECI    = 5'h12;
  localparam logic [4:0] SIG_T0     = 5'h13;
  localparam logic [4:0] SIG_T1     = 5'h14;
  localparam int         NUM_CEX    = 5;

  // fixed serial port pins
  localparam logic [4:0] TX_PIN = 5'h04;
  localparam logic [4:0] RX_PIN = 5'h05;

  // register byte offsets
  localparam logic [7:0] OFS_PORT     = 8'h00;
  localparam logic [7:0] OFS_INMODE   = 8'h10;
  localparam logic [7:0] OFS_OUTMODE  = 8'h20;
  localparam logic [7:0] OFS_SKIP     = 8'h30;
  localparam logic [7:0] OFS_SEL0     = 8'h40;
  localparam logic [7:0] OFS_SEL1     = 8'h44;
  localparam logic [7:0] OFS_SPI_MODE = 8'h48;
  localparam logic [7:0] OFS_ROUTED   = 8'h4C;
  localparam logic [7:0] OFS_LATCH    = 8'h50;

  // reset values
  localparam logic [7:0] RST_PORT     = 8'hFF;
  localparam logic [7:0] RST_INMODE   = 8'hFF;
  localparam logic [7:0] RST_OUTMODE  = 8'h00;
  localparam logic [7:0] RST_SKIP     = 8'h00;
  localparam logic [7:0] RST_SEL      = 8'h00;
  localparam logic [1:0] RST_SPI_MODE = 2'h0;

  // field positions in peripheral_select_0 / _1
  localparam int SEL0_UART_BIT = 0;
  localparam int SEL0_SPI_BIT  = 1;
  localparam int SEL0_SMB_BIT  = 2;
  localparam int SEL0_SYS_BIT  = 3;
  localparam int SEL0_CP0_BIT  = 4;
  localparam int SEL0_CP0A_BIT = 5;
  localparam int SEL0_CP1_BIT  = 6;
  localparam int SEL0_CP1A_BIT = 7;
  localparam int SEL1_ECI_BIT  = 3;
  localparam int SEL1_T0_BIT   = 4;
  localparam int SEL1_T1_BIT   = 5;
  localparam int SEL1_RTE_BIT  = 6;
  localparam int SEL1_WPUD_BIT = 7;

  // bus data phase
  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_RD_WAIT = 2'b01,
    PH_RD_DONE = 2'b11,
    PH_WR      = 2'b10
  } bus_phase_t;

endpackage

// *** design/priority_port_crossbar.sv ***
// priority crossbar, pin control and ahb-lite register slave
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module priority_port_crossbar
(
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic                                   hreadyout,
  output logic                                   hresp,
  output logic      [31:0]                       hrdata,
  input  wire logic [pin_xbar_pkg::NUM_SIGS-1:0] periph_out,
  input  wire logic [pin_xbar_pkg::NUM_SIGS-1:0] periph_oe,
  output logic      [pin_xbar_pkg::NUM_SIGS-1:0] periph_in,
  input  wire logic [pin_xbar_pkg::NUM_PINS-1:0] pin_in,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0] pin_out,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0] pin_oe,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0] pin_pullup_en,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0] pin_rx_en
);
  import pin_xbar_pkg::*;

  // flatten four port bytes into the 29-pin vector
  function automatic logic [NUM_PINS-1:0] flat_pins(input logic [7:0] b0, input logic [7:0] b1,
                                                    input logic [7:0] b2, input logic [7:0] b3);
    flat_pins = {b3[4:0], b2, b1, b0};
  endfunction

  // pick one port byte out of the 29-pin vector; port 3 reads zero above its five pins
  function automatic logic [7:0] port_byte(input logic [NUM_PINS-1:0] v, input logic [1:0] idx);
    logic [31:0] w;
    w         = {3'b000, v};
    port_byte = w[{idx, 3'b000} +: 8];
  endfunction

  bus_phase_t                phase_q;
  logic       [7:0]          addr_q;
  logic                      addr_ok_q;
  logic       [31:0]         rd_data;
  logic       [7:0]          port_latch_q [NUM_PORTS];
  logic       [7:0]          in_mode_q    [NUM_PORTS];
  logic       [7:0]          out_mode_q   [NUM_PORTS];
  logic       [7:0]          skip_q       [NUM_SKIP];
  logic       [7:0]          sel0_q, sel1_q;
  logic       [1:0]          spi_mode_q;
  logic       [NUM_PINS-1:0] sync1_q, sync2_q, sync3_q;
  logic       [NUM_PINS-1:0] pin_lvl_q;
  logic       [NUM_PINS-1:0] pin_rd;
  logic       [NUM_PINS-1:0] latch_vec, in_mode_vec, out_mode_vec;
  logic       [NUM_ROUTABLE-1:0] skip_vec;
  logic       [NUM_SIGS-1:0] sig_sel;
  logic       [NUM_SIGS-1:0] sig_valid;
  logic       [4:0]          sig_pin [NUM_SIGS];
  logic       [NUM_ROUTABLE-1:0] pin_valid;
  logic       [4:0]          pin_sig [NUM_ROUTABLE];
  logic                      route_en, wpud;
  logic       [NUM_PINS-1:0] pin_out_d, pin_oe_d, pin_pull_d;
  logic       [NUM_PINS-1:0] od_vec, smb_vec;
  logic                      wr_en, accept;

  assign latch_vec    = flat_pins(port_latch_q[0], port_latch_q[1], port_latch_q[2], port_latch_q[3]);
  assign in_mode_vec  = flat_pins(in_mode_q[0], in_mode_q[1], in_mode_q[2], in_mode_q[3]);
  assign out_mode_vec = flat_pins(out_mode_q[0], out_mode_q[1], out_mode_q[2], out_mode_q[3]);
  assign skip_vec     = {skip_q[2][3:0], skip_q[1], skip_q[0]};
  assign route_en     = sel1_q[SEL1_RTE_BIT];
  assign wpud         = sel1_q[SEL1_WPUD_BIT];

  // bus handshake: reads insert one wait so data reflects any write just before
  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = (phase_q != PH_RD_WAIT);
  assign hresp     = 1'b0;
  assign wr_en     = (phase_q == PH_WR) & addr_ok_q;

  // data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q   <= PH_IDLE;
      addr_q    <= 8'h00;
      addr_ok_q <= 1'b0;
    end else if (accept) begin
      phase_q   <= hwrite ? PH_WR : PH_RD_WAIT;
      addr_q    <= haddr[7:0];
      addr_ok_q <= (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);
    end else begin
      unique case (phase_q)
        PH_RD_WAIT: phase_q <= PH_RD_DONE;
        PH_RD_DONE: phase_q <= PH_IDLE;
        PH_WR:      phase_q <= PH_IDLE;
        PH_IDLE:    phase_q <= PH_IDLE;
      endcase
    end
  end

  // port latches take written values; the pins never feed back into them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_latch_q[i] <= RST_PORT;
      end
    end else if (wr_en && addr_q[7:4] == OFS_PORT[7:4]) begin
      port_latch_q[addr_q[3:2]] <= hwdata[7:0];
    end
  end

  // input and output mode masks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        in_mode_q[i]  <= RST_INMODE;
        out_mode_q[i] <= RST_OUTMODE;
      end
    end else if (wr_en) begin
      if (addr_q[7:4] == OFS_INMODE[7:4]) begin
        in_mode_q[addr_q[3:2]] <= hwdata[7:0];
      end
      if (addr_q[7:4] == OFS_OUTMODE[7:4]) begin
        out_mode_q[addr_q[3:2]] <= hwdata[7:0];
      end
    end
  end

  // skip masks, selects and spi mode; order of writes is up to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_SKIP; i++) begin
        skip_q[i] <= RST_SKIP;
      end
      sel0_q     <= RST_SEL;
      sel1_q     <= RST_SEL;
      spi_mode_q <= RST_SPI_MODE;
    end else if (wr_en) begin
      if (addr_q[7:4] == OFS_SKIP[7:4] && addr_q[3:2] != 2'd3) begin
        skip_q[addr_q[3:2]] <= hwdata[7:0];
      end
      if (addr_q == OFS_SEL0) begin
        sel0_q <= hwdata[7:0];
      end
      if (addr_q == OFS_SEL1) begin
        sel1_q <= hwdata[7:0];
      end
      if (addr_q == OFS_SPI_MODE) begin
        spi_mode_q <= hwdata[1:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h00000000;
    if (addr_ok_q) begin
      unique case (addr_q[7:4])
        4'h0: rd_data[7:0] = port_byte(pin_rd, addr_q[3:2]);
        4'h1: rd_data[7:0] = in_mode_q[addr_q[3:2]];
        4'h2: rd_data[7:0] = out_mode_q[addr_q[3:2]];
        4'h3: rd_data[7:0] = (addr_q[3:2] == 2'd3) ? 8'h00 : skip_q[addr_q[3:2]];
        4'h4: begin
          unique case (addr_q)
            OFS_SEL0:     rd_data[7:0] = sel0_q;
            OFS_SEL1:     rd_data[7:0] = sel1_q;
            OFS_SPI_MODE: rd_data[1:0] = spi_mode_q;
            OFS_ROUTED:   rd_data[NUM_ROUTABLE-1:0] = pin_valid;
            default:      rd_data = 32'h00000000;
          endcase
        end
        4'h5: rd_data[7:0] = port_latch_q[addr_q[3:2]];
        default: rd_data = 32'h00000000;
      endcase
    end
  end

  // read data captured in the wait cycle, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (phase_q == PH_RD_WAIT) begin
      hrdata <= rd_data;
    end
  end

  // pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q   <= '1;
      sync2_q   <= '1;
      sync3_q   <= '1;
      pin_lvl_q <= '1;
    end else begin
      sync1_q   <= pin_in;
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      pin_lvl_q <= (pin_lvl_q & (sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));
    end
  end

  // analog pins have no receiver, so they read high
  assign pin_rd = pin_lvl_q | ~in_mode_vec;

  // which peripheral signals want a pin
  always_comb begin
    sig_sel                = '0;
    sig_sel[SIG_TX]        = sel0_q[SEL0_UART_BIT];
    sig_sel[SIG_RX]        = sel0_q[SEL0_UART_BIT];
    sig_sel[SIG_SCK]       = sel0_q[SEL0_SPI_BIT];
    sig_sel[SIG_MISO]      = sel0_q[SEL0_SPI_BIT];
    sig_sel[SIG_MOSI]      = sel0_q[SEL0_SPI_BIT];
    sig_sel[SIG_NSS]       = sel0_q[SEL0_SPI_BIT] & (spi_mode_q != 2'b00);
    sig_sel[SIG_SDA]       = sel0_q[SEL0_SMB_BIT];
    sig_sel[SIG_SCL]       = sel0_q[SEL0_SMB_BIT];
    sig_sel[SIG_CP0]       = sel0_q[SEL0_CP0_BIT];
    sig_sel[SIG_CP0A]      = sel0_q[SEL0_CP0A_BIT];
    sig_sel[SIG_CP1]       = sel0_q[SEL0_CP1_BIT];
    sig_sel[SIG_CP1A]      = sel0_q[SEL0_CP1A_BIT];
    sig_sel[SIG_SYSCLK]    = sel0_q[SEL0_SYS_BIT];
    for (int k = 0; k < NUM_CEX; k++) begin
      sig_sel[SIG_CEX0 + k] = (sel1_q[2:0] > 3'(k));
    end
    sig_sel[SIG_ECI]       = sel1_q[SEL1_ECI_BIT];
    sig_sel[SIG_T0]        = sel1_q[SEL1_T0_BIT];
    sig_sel[SIG_T1]        = sel1_q[SEL1_T1_BIT];
  end

  // priority decoder, purely combinational so changes land next edge
  always_comb begin
    logic [NUM_ROUTABLE-1:0] taken;
    logic                    found;
    taken     = skip_vec;
    found     = 1'b0;
    pin_valid = '0;
    sig_valid = '0;
    pin_sig   = '{default: 5'h00};
    sig_pin   = '{default: 5'h00};
    if (route_en) begin
      if (sel0_q[SEL0_UART_BIT]) begin
        pin_valid[TX_PIN] = 1'b1;
        pin_sig[TX_PIN]   = SIG_TX;
        pin_valid[RX_PIN] = 1'b1;
        pin_sig[RX_PIN]   = SIG_RX;
        sig_valid[SIG_TX] = 1'b1;
        sig_pin[SIG_TX]   = TX_PIN;
        sig_valid[SIG_RX] = 1'b1;
        sig_pin[SIG_RX]   = RX_PIN;
        taken[TX_PIN]     = 1'b1;
        taken[RX_PIN]     = 1'b1;
      end
      // remaining signals in priority order, each on the lowest free pin
      for (int s = SIG_SCK; s < NUM_SIGS; s++) begin
        found = 1'b0;
        if (sig_sel[s]) begin
          for (int p = 0; p < NUM_ROUTABLE; p++) begin
            if (!found && !taken[p]) begin
              found        = 1'b1;
              taken[p]     = 1'b1;
              pin_valid[p] = 1'b1;
              pin_sig[p]   = 5'(s);
              sig_valid[s] = 1'b1;
              sig_pin[s]   = 5'(p);
            end
          end
        end
      end
    end
  end

  // per-pin drive, open-drain choice and pullup
  always_comb begin
    logic       routed;
    logic [4:0] sg;
    logic       val;
    logic       want;
    routed = 1'b0;
    sg     = 5'h00;
    val    = 1'b0;
    want   = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      routed = 1'b0;
      sg     = 5'h00;
      if (p < NUM_ROUTABLE) begin
        routed = pin_valid[p];
        sg     = pin_sig[p];
      end
      // unrouted pins act as ordinary port pins from the latch
      val        = routed ? periph_out[sg] : latch_vec[p];
      want       = routed ? periph_oe[sg] : 1'b1;
      smb_vec[p] = routed & (sg == SIG_SDA || sg == SIG_SCL);
      od_vec[p]  = ~out_mode_vec[p] | smb_vec[p];
      pin_out_d[p] = 1'b0;
      pin_oe_d[p]  = 1'b0;
      if (route_en && in_mode_vec[p]) begin
        if (od_vec[p]) begin
          pin_oe_d[p] = want & ~val;
        end else begin
          pin_out_d[p] = val;
          pin_oe_d[p]  = want;
        end
      end
      // pullup only on digital open-drain pins, and never while pulling low
      pin_pull_d[p] = in_mode_vec[p] & od_vec[p] & ~wpud & ~pin_oe_d[p];
    end
  end

  // pin outputs and peripheral inputs come from flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out       <= '0;
      pin_oe        <= '0;
      pin_pullup_en <= '0;
      pin_rx_en     <= '1;
      periph_in     <= '1;
    end else begin
      pin_out       <= pin_out_d;
      pin_oe        <= pin_oe_d;
      pin_pullup_en <= pin_pull_d;
      pin_rx_en     <= in_mode_vec;
      for (int s = 0; s < NUM_SIGS; s++) begin
        periph_in[s] <= sig_valid[s] ? pin_rd[sig_pin[s]] : 1'b1;
      end
    end
  end

  // checks on the decoder and the pin cells
  AST_UART_FIXED: assert property (@(posedge hclk) disable iff (!hresetn)
    (route_en && sel0_q[SEL0_UART_BIT]) |-> (pin_valid[TX_PIN] && pin_sig[TX_PIN] == SIG_TX
                                            && pin_valid[RX_PIN] && pin_sig[RX_PIN] == SIG_RX))
    else $error("serial port not on its fixed pins");
  AST_SKIP_HONOURED: assert property (@(posedge hclk) disable iff (!hresetn)
    ((pin_valid & skip_vec & ~(20'h00001 << TX_PIN) & ~(20'h00001 << RX_PIN)) == '0))
    else $error("skipped pin was assigned");
  AST_LOWEST_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
    (route_en && sel0_q[SEL0_SPI_BIT] && !sel0_q[SEL0_UART_BIT] && skip_vec == '0)
      |-> (pin_sig[0] == SIG_SCK && pin_sig[1] == SIG_MISO && pin_sig[2] == SIG_MOSI))
    else $error("spi not placed on lowest free pins");
  AST_PAIR_CLAIM: assert property (@(posedge hclk) disable iff (!hresetn)
    (sig_valid[SIG_SDA] == sig_valid[SIG_SCL]) && (sig_valid[SIG_TX] == sig_valid[SIG_RX]))
    else $error("paired signals claimed apart");
  AST_NSS_MODE: assert property (@(posedge hclk) disable iff (!hresetn)
    (spi_mode_q == 2'b00) |-> !sig_valid[SIG_NSS])
    else $error("slave select routed in 3-wire mode");
  // registered drivers lag the enable by one edge, the decoder follows it at once
  AST_DRIVERS_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(route_en) || pin_oe == '0) && (route_en || pin_valid == '0))
    else $error("pin driven while routing disabled");
  AST_ANALOG_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
    ((~$past(in_mode_vec) & (pin_oe | pin_pullup_en | pin_rx_en)) == '0))
    else $error("analog pin not isolated");
  AST_SMB_OPEN_DRAIN: assert property (@(posedge hclk) disable iff (!hresetn)
    (($past(smb_vec) & pin_oe & pin_out) == '0))
    else $error("bus pin driven high");
  AST_PULLUP_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    ((pin_pullup_en & pin_oe & ~pin_out) == '0))
    else $error("pullup on while driving low");
  AST_PUSH_PULL_NO_PULL: assert property (@(posedge hclk) disable iff (!hresetn)
    ((pin_pullup_en & ~$past(od_vec)) == '0))
    else $error("pullup on push-pull pin");
  AST_LATCH_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_q[7:4] == OFS_PORT[7:4]) |=> (port_latch_q[$past(addr_q[3:2])] == $past(hwdata[7:0])))
    else $error("port write not latched");

  // main scenarios
  COV_UART_ROUTED: cover property (@(posedge hclk) disable iff (!hresetn) route_en && sig_valid[SIG_TX]);
  COV_SMB_ROUTED: cover property (@(posedge hclk) disable iff (!hresetn)
    route_en && sig_valid[SIG_SDA] && sig_valid[SIG_SCL]);
  COV_NSS_ROUTED: cover property (@(posedge hclk) disable iff (!hresetn) sig_valid[SIG_NSS]);
  COV_READ_DONE: cover property (@(posedge hclk) disable iff (!hresetn)
    phase_q == PH_RD_WAIT ##1 phase_q == PH_RD_DONE);

endmodule // priority_port_crossbar

// *** verif/pin_board_model.sv ***
// board-side model of the port pins with external pull-downs
`timescale 1ns/1ps
module pin_board_model
  import pin_xbar_pkg::*;
(
  input  wire logic                              hclk,
  input  wire logic [pin_xbar_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [pin_xbar_pkg::NUM_PINS-1:0] pin_oe,
  input  wire logic [pin_xbar_pkg::NUM_PINS-1:0] pin_pullup_en,
  input  wire logic [pin_xbar_pkg::NUM_PINS-1:0] ext_low,
  output logic      [pin_xbar_pkg::NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] float_q = '0;

  // an undriven pin without pullup wanders, so it never reads as a steady level
  always_ff @(posedge hclk) begin
    float_q <= ~float_q;
  end

  // board pull-down wins, then the pin driver, then the weak pullup
  assign pin_in = ~ext_low & ((pin_oe & pin_out) | (~pin_oe & (pin_pullup_en | float_q)));
endmodule // pin_board_model

// *** verif/tb_priority_port_crossbar.sv ***
// self-checking bench for the priority port crossbar
`timescale 1ns/1ps
module tb_priority_port_crossbar;
  import pin_xbar_pkg::*;
  logic                hclk          = 1'b0;
  logic                hresetn       = 1'b0;
  logic [31:0]         haddr         = 32'h0;
  logic [31:0]         hwdata        = 32'h0;
  logic [1:0]          htrans        = 2'h0;
  logic                hwrite        = 1'b0;
  logic [NUM_SIGS-1:0] periph_out    = '1;
  logic [NUM_SIGS-1:0] periph_oe     = '1;
  logic [NUM_PINS-1:0] ext_low       = '0;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  logic [NUM_SIGS-1:0] periph_in;
  logic [NUM_PINS-1:0] pin_in;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_PINS-1:0] pin_pullup_en;
  logic [NUM_PINS-1:0] pin_rx_en;
  int                  n_errors      = 0;
  int                  checks_done   = 0;

  // 125 MHz system clock
  always #4 hclk = ~hclk;

  priority_port_crossbar dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_rx_en(pin_rx_en)
  );

  pin_board_model board_u (
    .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .ext_low(ext_low), .pin_in(pin_in)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready is sampled at the rising edge; the slave only moves it after that edge
  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk($sformatf("reg %h", a), exp, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // pin outputs are registered, so look just after the edge has landed
  task automatic pause(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog well beyond the fewer than 200 cycles the sequence needs
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  // configuration follows output modes, port latch, skips, selects, enable
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    pause(2);
    chk("rx_en", 32'h1FFFFFFF, {3'h0, pin_rx_en});
    chk("pullup", 32'h1FFFFFFF, {3'h0, pin_pullup_en});
    rd(8'h10, 32'h000000FF);
    rd(8'h20, 32'h00000000);
    wr(8'h20, 32'h000000FF);
    wr(8'h2C, 32'h0000001F);
    wr(8'h0C, 32'h0000000A);
    rd(8'h5C, 32'h0000000A);
    pause(2);
    chk("oe off", 32'h0, {3'h0, pin_oe});
    // skip P0.0 as if the reference used it; uart, spi, smbus, cp0 selected, 3-wire spi
    wr(8'h30, 32'h00000001);
    wr(8'h40, 32'h00000017);
    wr(8'h44, 32'h00000040);
    rd(8'h4C, 32'h000001FE);
    wr(8'h48, 32'h00000001);
    rd(8'h4C, 32'h000003FE);
    pause(2);
    chk("p3 oe", 32'h1F, {27'h0, pin_oe[28:24]});
    chk("p3 out", 32'h0A, {27'h0, pin_out[28:24]});
    chk("tx pin", 32'h3, {30'h0, pin_oe[4], pin_out[4]});
    chk("sda high", 32'h0, {31'h0, pin_oe[7]});
    @(posedge hclk) periph_out[SIG_SDA] <= 1'b0;
    pause(2);
    chk("sda low", 32'h4, {29'h0, pin_oe[7], pin_out[7], pin_pullup_en[7]});
    @(posedge hclk) ext_low <= 29'h00002100;
    pause(6);
    rd(8'h04, 32'h000000DE);
    chk("periph in", 32'h2, {30'h0, periph_in[SIG_T0], periph_in[SIG_SCL]});
    wr(8'h18, 32'h00000000);
    pause(2);
    chk("p2 rx", 32'h0, {24'h0, pin_rx_en[23:16]});
    chk("p2 pu", 32'h0, {19'h0, pin_pullup_en[28:16]});
    chk("p2 oe", 32'h0, {24'h0, pin_oe[23:16]});
    rd(8'h08, 32'h000000FF);
    chk("p1 pu", 32'h3, {30'h0, pin_pullup_en[15:14]});
    wr(8'h44, 32'h000000C0);
    pause(2);
    chk("p1 pu off", 32'h0, {26'h0, pin_pullup_en[15:10]});
    chk("p3 kept", 32'h1F, {27'h0, pin_oe[28:24]});
    // every routable pin skipped: only the fixed serial pins remain
    wr(8'h44, 32'h00000040);
    wr(8'h30, 32'h000000FF);
    wr(8'h34, 32'h000000FF);
    wr(8'h38, 32'h0000000F);
    rd(8'h4C, 32'h00000030);
    // spi alone in 4-wire mode with two capture units, nothing skipped
    wr(8'h30, 32'h00000000);
    wr(8'h34, 32'h00000000);
    wr(8'h38, 32'h00000000);
    wr(8'h40, 32'h00000002);
    wr(8'h44, 32'h00000042);
    rd(8'h4C, 32'h0000003F);
    wr(8'h44, 32'h00000000);
    pause(2);
    chk("oe disabled", 32'h0, {3'h0, pin_oe});
    rd(8'h4C, 32'h00000000);
    rd(8'h64, 32'h00000000);
    summarize();
  end
endmodule // tb_priority_port_crossbar
